// [rtl/pdma_cfg.svh]
/*
  Constants of the packet descriptor DMA: descriptor layout, flag positions,
  length limits and channel usage.
  Assumes it is included by bare name from the design files and the bench.
*/
// Function
// - four transmit, two receive channels (0 and 1), independent state
// - fixed mapping of channels to the two MACs
// - MAC side and memory side share clock
// - transmit: fetch descriptor, write control, then move
// - core's handshake paces every data word
// - core requests status read; written to descriptor
// - receive: fetch descriptor, write control, then move
// - received words stored into descriptor buffers
// - receive status read and written into descriptor
// - end-of-buffer event pulsed for one cycle when INTR bit set
// - per-channel table pointer locates descriptors
// - wrap flag returns to table start
// - automatic return after 256 descriptors
// - status/control: six engine bits, ten core bits
// - length halfword, then 32-bit buffer pointer
// - buffer length capped at 4080 bytes
// - transmit moves exactly the descriptor length
// - receive writes back bytes actually stored
// - packets chain over any number of buffers
// - each descriptor checked on arrival; error if unready after the first
// - requests accepted only from active channels
// - buffer processed only when ready flag set
`ifndef PDMA_CFG_SVH
`define PDMA_CFG_SVH

`define PDMA_DESC_SHIFT   3
`define PDMA_IDX_W        8
`define PDMA_BIT_READY    15
`define PDMA_BIT_WRAP     14
`define PDMA_BIT_LAST     11
`define PDMA_BIT_INTR     10
`define PDMA_CORE_W       10
`define PDMA_MAX_BUF_LEN  12'hFF0
`define PDMA_RX_USED_MASK 4'h3
`define PDMA_WORD_BYTES   3'h4

`endif

// [rtl/pdma_pkg.sv]
/*
  Types of the packet descriptor DMA: the engine state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pdma_pkg;

  typedef enum logic [9:0] {
    PDMA_IDLE     = 10'h001,
    PDMA_RD_CTL   = 10'h002,
    PDMA_RD_PTR   = 10'h004,
    PDMA_CHECK    = 10'h008,
    PDMA_CTRL     = 10'h010,
    PDMA_MOVE_MEM = 10'h020,
    PDMA_MOVE_MAC = 10'h040,
    PDMA_WAIT_STS = 10'h080,
    PDMA_WR_CTL   = 10'h100,
    PDMA_NEXT     = 10'h200
  } pdma_state_t;

endpackage : pdma_pkg

// [rtl/pdma_arb.sv]
/*
  Fixed-priority request picker; the lowest requesting index wins.
  Assumes requests are already masked by channel enables.
*/
`timescale 1ns/1ps

module pdma_arb #(
  parameter int N  = 4,
  parameter int IW = 2
) (
  input  wire logic [N-1:0]  i_req,     // masked requests
  output logic               o_vld,     // some request present
  output logic [IW-1:0]      o_idx      // winning channel
);

  always_comb begin
    o_vld = 1'b0;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_vld = 1'b1;
        o_idx = IW'(i);
      end
    end
  end

endmodule : pdma_arb

// [rtl/pdma_top.sv]
/*
  Packet descriptor DMA engine: one shared engine serving four transmit and
  two receive MAC channels (0 and 1), walking per-channel circular descriptor tables.
  Assumes a single clock for memory bus and MAC side, a simple memory master
  handshake (request held until a one-cycle acknowledge) and word-aligned
  data buffers.
*/
`timescale 1ns/1ps
`include "pdma_cfg.svh"

module pdma_top #(
  parameter int NCH = 4,
  parameter int CW  = 2
) (
  input  wire logic                 i_clk,            // 250 MHz clock
  input  wire logic                 i_rst,            // sync reset, high
  // channel setup
  input  wire logic [NCH-1:0]       i_tx_act,         // tx channel active
  input  wire logic [NCH-1:0]       i_rx_act,         // rx channel active
  input  wire logic [NCH*32-1:0]    i_tx_tbl,         // tx table pointers
  input  wire logic [NCH*32-1:0]    i_rx_tbl,         // rx table pointers
  // memory master
  output logic                      o_mem_req,        // access request
  output logic                      o_mem_we,         // write access
  output logic [31:0]               o_mem_addr,       // byte address
  output logic [31:0]               o_mem_wdata,      // write data
  output logic [3:0]                o_mem_be,         // byte enables
  input  wire logic                 i_mem_ack,        // access done
  input  wire logic [31:0]          i_mem_rdata,      // read data
  // MAC control and status
  input  wire logic [NCH-1:0]       i_tx_req,         // tx service request
  input  wire logic [NCH-1:0]       i_rx_req,         // rx service request
  output logic [NCH-1:0]            o_tx_ctrl_vld,    // tx control pulse
  output logic [NCH-1:0]            o_rx_ctrl_vld,    // rx control pulse
  output logic [`PDMA_CORE_W-1:0]   o_ctrl_word,      // core control bits
  input  wire logic [NCH-1:0]       i_tx_sts_req,     // tx status ready
  input  wire logic [NCH-1:0]       i_rx_sts_req,     // rx status ready
  input  wire logic [`PDMA_CORE_W-1:0] i_tx_sts,      // tx status bits
  input  wire logic [`PDMA_CORE_W-1:0] i_rx_sts,      // rx status bits
  // transmit data
  output logic [NCH-1:0]            o_tx_data_vld,    // tx word valid
  input  wire logic [NCH-1:0]       i_tx_data_rdy,    // tx word taken
  output logic [31:0]               o_tx_data,        // tx word
  output logic [2:0]                o_tx_data_bytes,  // bytes in word
  output logic [NCH-1:0]            o_tx_eop,         // packet end pulse
  // receive data
  input  wire logic [NCH-1:0]       i_rx_data_vld,    // rx word valid
  output logic [NCH-1:0]            o_rx_data_rdy,    // rx word taken
  input  wire logic [31:0]          i_rx_data,        // rx word
  input  wire logic                 i_rx_last,        // last word of packet
  input  wire logic [2:0]           i_rx_last_bytes,  // bytes in last word
  // events
  output logic [NCH-1:0]            o_tx_unavail,     // first desc not ready
  output logic [NCH-1:0]            o_rx_unavail,     // first desc not ready
  output logic [NCH-1:0]            o_tx_desc_err,    // mid-packet not ready
  output logic [NCH-1:0]            o_rx_desc_err,    // mid-packet not ready
  output logic [NCH-1:0]            o_tx_eob,         // end-of-buffer event
  output logic [NCH-1:0]            o_rx_eob,         // end-of-buffer event
  output logic [NCH-1:0]            o_tx_halted,      // channel stopped
  output logic [NCH-1:0]            o_rx_halted       // channel stopped
);

  ////////////////////////////////////////////////////////////////////////////
  // channel selection

  pdma_pkg::pdma_state_t state_r;

  logic [NCH-1:0] tx_dis_r;
  logic [NCH-1:0] rx_dis_r;
  logic [NCH-1:0] tx_req_m;
  logic [NCH-1:0] rx_req_m;
  logic           tx_vld;
  logic           rx_vld;
  logic [CW-1:0]  tx_win;
  logic [CW-1:0]  rx_win;
  logic           last_tx_r;
  logic           pick_rx;

  assign tx_req_m = i_tx_req & i_tx_act & ~tx_dis_r;
  assign rx_req_m = i_rx_req & i_rx_act & ~rx_dis_r & NCH'(`PDMA_RX_USED_MASK);

  pdma_arb #(.N(NCH), .IW(CW)) u_tx_arb (
    .i_req (tx_req_m),
    .o_vld (tx_vld),
    .o_idx (tx_win)
  );

  pdma_arb #(.N(NCH), .IW(CW)) u_rx_arb (
    .i_req (rx_req_m),
    .o_vld (rx_vld),
    .o_idx (rx_win)
  );

  // alternate directions so neither starves the other
  assign pick_rx = rx_vld & (~tx_vld | last_tx_r);

  ////////////////////////////////////////////////////////////////////////////
  // per-channel descriptor index

  logic [`PDMA_IDX_W-1:0] tx_idx_r [NCH];
  logic [`PDMA_IDX_W-1:0] rx_idx_r [NCH];
  logic                   cur_rx_r;
  logic [CW-1:0]          cur_ch_r;
  logic [15:0]            ctl_r;
  logic [NCH-1:0]         sel_oh;
  logic [`PDMA_IDX_W-1:0] cur_idx;
  logic [31:0]            cur_tbl;
  logic [31:0]            desc_addr;

  assign sel_oh    = NCH'(1) << cur_ch_r;
  assign cur_idx   = cur_rx_r ? rx_idx_r[cur_ch_r] : tx_idx_r[cur_ch_r];
  assign cur_tbl   = cur_rx_r ? i_rx_tbl[cur_ch_r*32 +: 32] : i_tx_tbl[cur_ch_r*32 +: 32];
  // low three address bits come from the table pointer alone
  assign desc_addr = cur_tbl + {21'h0, cur_idx, 3'h0};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NCH; i++) begin
        tx_idx_r[i] <= '0;
        rx_idx_r[i] <= '0;
      end
    end else if (state_r == pdma_pkg::PDMA_NEXT) begin
      if (cur_rx_r) begin
        // eight-bit index rolls over to entry 0 after 256 descriptors
        rx_idx_r[cur_ch_r] <= ctl_r[`PDMA_BIT_WRAP] ? '0 : rx_idx_r[cur_ch_r] + 1'b1;
      end else begin
        tx_idx_r[cur_ch_r] <= ctl_r[`PDMA_BIT_WRAP] ? '0 : tx_idx_r[cur_ch_r] + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine datapath

  logic [11:0]             len_r;
  logic [31:0]             ptr_r;
  logic [11:0]             off_r;
  logic [31:0]             word_r;
  logic [2:0]              wbytes_r;
  logic                    first_r;
  logic                    eop_r;
  logic [`PDMA_CORE_W-1:0] sts_r;
  logic                    mem_go_r;
  logic [11:0]             rem;
  logic [2:0]              tx_bytes;
  logic [11:0]             len_clamp;
  logic [15:0]             ctl_out;
  logic [11:0]             len_out;
  logic [31:0]             addr_c;
  logic [31:0]             wdata_c;
  logic                    we_c;
  logic [3:0]              be_c;
  logic                    mem_done;
  logic                    sts_hit;

  assign rem       = len_r - off_r;
  assign tx_bytes  = (rem >= 12'h004) ? `PDMA_WORD_BYTES : rem[2:0];
  assign len_clamp = (i_mem_rdata[15:0] > {4'h0, `PDMA_MAX_BUF_LEN}) ?
                     `PDMA_MAX_BUF_LEN : i_mem_rdata[11:0];
  assign mem_done  = o_mem_req & i_mem_ack;
  assign sts_hit   = cur_rx_r ? i_rx_sts_req[cur_ch_r] : i_tx_sts_req[cur_ch_r];

  // ready cleared so the entry is not reused until software refills it
  assign ctl_out = {1'b0, ctl_r[14:12], (ctl_r[`PDMA_BIT_LAST] | eop_r), ctl_r[10],
                    eop_r ? sts_r : ctl_r[9:0]};
  assign len_out = cur_rx_r ? off_r : len_r;

  always_comb begin
    addr_c  = desc_addr;
    wdata_c = {ctl_out, 4'h0, len_out};
    we_c    = 1'b0;
    be_c    = 4'hF;
    case (state_r)
      pdma_pkg::PDMA_RD_PTR:   addr_c = desc_addr + 32'h4;
      pdma_pkg::PDMA_WR_CTL:   we_c = 1'b1;
      pdma_pkg::PDMA_MOVE_MEM: begin
        addr_c  = ptr_r + {20'h0, off_r};
        wdata_c = word_r;
        we_c    = cur_rx_r;
        case (wbytes_r)
          3'h1:    be_c = 4'h8;
          3'h2:    be_c = 4'hC;
          3'h3:    be_c = 4'hE;
          default: be_c = 4'hF;
        endcase
      end
      default: ;
    endcase
  end

  // one launch per memory state; request held until acknowledged
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 32'h0;
      o_mem_wdata <= 32'h0;
      o_mem_be    <= 4'h0;
    end else if (mem_go_r) begin
      o_mem_req   <= 1'b1;
      o_mem_we    <= we_c;
      o_mem_addr  <= addr_c;
      o_mem_wdata <= wdata_c;
      o_mem_be    <= be_c;
    end else if (i_mem_ack) begin
      o_mem_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine sequence

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r   <= pdma_pkg::PDMA_IDLE;
      mem_go_r  <= 1'b0;
      cur_rx_r  <= 1'b0;
      cur_ch_r  <= '0;
      last_tx_r <= 1'b0;
      first_r   <= 1'b0;
      eop_r     <= 1'b0;
      ctl_r     <= 16'h0;
      len_r     <= 12'h0;
      ptr_r     <= 32'h0;
      off_r     <= 12'h0;
      word_r    <= 32'h0;
      wbytes_r  <= 3'h0;
      sts_r     <= '0;
    end else begin
      mem_go_r <= 1'b0;
      case (state_r)
        pdma_pkg::PDMA_IDLE: begin
          if (tx_vld | rx_vld) begin
            cur_rx_r  <= pick_rx;
            cur_ch_r  <= pick_rx ? rx_win : tx_win;
            last_tx_r <= ~pick_rx;
            first_r   <= 1'b1;
            eop_r     <= 1'b0;
            mem_go_r  <= 1'b1;
            state_r   <= pdma_pkg::PDMA_RD_CTL;
          end
        end
        pdma_pkg::PDMA_RD_CTL: begin
          if (mem_done) begin
            ctl_r    <= i_mem_rdata[31:16];
            len_r    <= len_clamp;
            mem_go_r <= 1'b1;
            state_r  <= pdma_pkg::PDMA_RD_PTR;
          end
        end
        pdma_pkg::PDMA_RD_PTR: begin
          if (mem_done) begin
            ptr_r   <= i_mem_rdata;
            off_r   <= 12'h0;
            state_r <= pdma_pkg::PDMA_CHECK;
          end
        end
        pdma_pkg::PDMA_CHECK: begin
          if (!ctl_r[`PDMA_BIT_READY]) begin
            state_r <= pdma_pkg::PDMA_IDLE;
          end else if (first_r) begin
            state_r <= pdma_pkg::PDMA_CTRL;
          end else if (cur_rx_r) begin
            state_r <= pdma_pkg::PDMA_MOVE_MAC;
          end else if (len_r == 12'h0) begin
            state_r <= pdma_pkg::PDMA_WR_CTL;
            mem_go_r <= 1'b1;
          end else begin
            state_r  <= pdma_pkg::PDMA_MOVE_MEM;
            mem_go_r <= 1'b1;
          end
        end
        pdma_pkg::PDMA_CTRL: begin
          first_r <= 1'b0;
          if (cur_rx_r) begin
            state_r <= pdma_pkg::PDMA_MOVE_MAC;
          end else if (len_r == 12'h0) begin
            state_r  <= ctl_r[`PDMA_BIT_LAST] ? pdma_pkg::PDMA_WAIT_STS : pdma_pkg::PDMA_WR_CTL;
            eop_r    <= ctl_r[`PDMA_BIT_LAST];
            mem_go_r <= ~ctl_r[`PDMA_BIT_LAST];
          end else begin
            state_r  <= pdma_pkg::PDMA_MOVE_MEM;
            mem_go_r <= 1'b1;
          end
        end
        pdma_pkg::PDMA_MOVE_MEM: begin
          if (mem_done) begin
            if (cur_rx_r) begin
              off_r <= off_r + {9'h0, wbytes_r};
              if (eop_r) begin
                state_r <= pdma_pkg::PDMA_WAIT_STS;
              end else if (off_r + {9'h0, wbytes_r} >= len_r) begin
                state_r  <= pdma_pkg::PDMA_WR_CTL;
                mem_go_r <= 1'b1;
              end else begin
                state_r <= pdma_pkg::PDMA_MOVE_MAC;
              end
            end else begin
              word_r   <= i_mem_rdata;
              wbytes_r <= tx_bytes;
              state_r  <= pdma_pkg::PDMA_MOVE_MAC;
            end
          end
        end
        pdma_pkg::PDMA_MOVE_MAC: begin
          if (cur_rx_r) begin
            if (i_rx_data_vld[cur_ch_r]) begin
              word_r   <= i_rx_data;
              wbytes_r <= i_rx_last ? i_rx_last_bytes : `PDMA_WORD_BYTES;
              eop_r    <= i_rx_last;
              mem_go_r <= 1'b1;
              state_r  <= pdma_pkg::PDMA_MOVE_MEM;
            end
          end else if (i_tx_data_rdy[cur_ch_r]) begin
            off_r <= off_r + {9'h0, wbytes_r};
            if (off_r + {9'h0, wbytes_r} >= len_r) begin
              eop_r    <= ctl_r[`PDMA_BIT_LAST];
              state_r  <= ctl_r[`PDMA_BIT_LAST] ? pdma_pkg::PDMA_WAIT_STS : pdma_pkg::PDMA_WR_CTL;
              mem_go_r <= ~ctl_r[`PDMA_BIT_LAST];
            end else begin
              state_r  <= pdma_pkg::PDMA_MOVE_MEM;
              mem_go_r <= 1'b1;
            end
          end
        end
        pdma_pkg::PDMA_WAIT_STS: begin
          if (sts_hit) begin
            sts_r    <= cur_rx_r ? i_rx_sts : i_tx_sts;
            mem_go_r <= 1'b1;
            state_r  <= pdma_pkg::PDMA_WR_CTL;
          end
        end
        pdma_pkg::PDMA_WR_CTL: begin
          if (mem_done) begin
            state_r <= pdma_pkg::PDMA_NEXT;
          end
        end
        pdma_pkg::PDMA_NEXT: begin
          if (eop_r) begin
            state_r <= pdma_pkg::PDMA_IDLE;
          end else begin
            state_r  <= pdma_pkg::PDMA_RD_CTL;
            mem_go_r <= 1'b1;
          end
        end
        default: state_r <= pdma_pkg::PDMA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel halt on descriptor error

  logic err_hit;
  logic nrdy_hit;

  assign nrdy_hit = (state_r == pdma_pkg::PDMA_CHECK) & ~ctl_r[`PDMA_BIT_READY];
  assign err_hit  = nrdy_hit & ~first_r;

  // stays halted until software drops the active bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_dis_r <= '0;
      rx_dis_r <= '0;
    end else begin
      tx_dis_r <= (tx_dis_r & i_tx_act) | ((err_hit & ~cur_rx_r) ? sel_oh : '0);
      rx_dis_r <= (rx_dis_r & i_rx_act) | ((err_hit & cur_rx_r) ? sel_oh : '0);
    end
  end

  assign o_tx_halted = tx_dis_r;
  assign o_rx_halted = rx_dis_r;

  ////////////////////////////////////////////////////////////////////////////
  // MAC-facing pulses and data

  logic ctrl_hit;
  logic eob_hit;
  logic eop_hit;

  assign ctrl_hit = (state_r == pdma_pkg::PDMA_CTRL);
  assign eob_hit  = (state_r == pdma_pkg::PDMA_NEXT) & ctl_r[`PDMA_BIT_INTR];
  assign eop_hit  = (state_r == pdma_pkg::PDMA_MOVE_MAC) & ~cur_rx_r & i_tx_data_rdy[cur_ch_r] &
                    (off_r + {9'h0, wbytes_r} >= len_r) & ctl_r[`PDMA_BIT_LAST];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_ctrl_vld <= '0;
      o_rx_ctrl_vld <= '0;
      o_ctrl_word   <= '0;
      o_tx_eop      <= '0;
      o_tx_unavail  <= '0;
      o_rx_unavail  <= '0;
      o_tx_desc_err <= '0;
      o_rx_desc_err <= '0;
      o_tx_eob      <= '0;
      o_rx_eob      <= '0;
    end else begin
      o_tx_ctrl_vld <= (ctrl_hit & ~cur_rx_r) ? sel_oh : '0;
      o_rx_ctrl_vld <= (ctrl_hit & cur_rx_r) ? sel_oh : '0;
      if (ctrl_hit) begin
        o_ctrl_word <= ctl_r[9:0];
      end
      o_tx_eop      <= eop_hit ? sel_oh : '0;
      o_tx_unavail  <= (nrdy_hit & first_r & ~cur_rx_r) ? sel_oh : '0;
      o_rx_unavail  <= (nrdy_hit & first_r & cur_rx_r) ? sel_oh : '0;
      o_tx_desc_err <= (err_hit & ~cur_rx_r) ? sel_oh : '0;
      o_rx_desc_err <= (err_hit & cur_rx_r) ? sel_oh : '0;
      o_tx_eob      <= (eob_hit & ~cur_rx_r) ? sel_oh : '0;
      o_rx_eob      <= (eob_hit & cur_rx_r) ? sel_oh : '0;
    end
  end

  assign o_tx_data       = word_r;
  assign o_tx_data_bytes = wbytes_r;
  assign o_tx_data_vld   = ((state_r == pdma_pkg::PDMA_MOVE_MAC) & ~cur_rx_r) ? sel_oh : '0;
  assign o_rx_data_rdy   = ((state_r == pdma_pkg::PDMA_MOVE_MAC) & cur_rx_r) ? sel_oh : '0;

endmodule : pdma_top

// [verif/pdma_top_asserts.sv]
/*
  Port checker for the packet DMA top: memory handshake, channel grants,
  transmit word offers and pulse widths.
  Assumes binding to pdma_top with its single clock and sync reset.
*/
`timescale 1ns/1ps
`include "pdma_cfg.svh"

module pdma_top_asserts #(
  parameter int NCH = 4,
  parameter int CW  = 2
) (
  input  wire logic             i_clk,           // clock
  input  wire logic             i_rst,           // sync reset
  input  wire logic [NCH-1:0]   i_tx_act,        // tx active
  input  wire logic [NCH-1:0]   i_rx_act,        // rx active
  input  wire logic             o_mem_req,       // memory request
  input  wire logic             o_mem_we,        // write
  input  wire logic [31:0]      o_mem_addr,      // address
  input  wire logic [31:0]      o_mem_wdata,     // write data
  input  wire logic             i_mem_ack,       // done
  input  wire logic [NCH-1:0]   o_tx_ctrl_vld,   // tx ctrl pulse
  input  wire logic [NCH-1:0]   o_rx_ctrl_vld,   // rx ctrl pulse
  input  wire logic [NCH-1:0]   o_tx_data_vld,   // tx offer
  input  wire logic [NCH-1:0]   i_tx_data_rdy,   // tx taken
  input  wire logic [31:0]      o_tx_data,       // tx word
  input  wire logic [2:0]       o_tx_data_bytes, // tx bytes
  input  wire logic [NCH-1:0]   o_tx_eop,        // packet end
  input  wire logic [NCH-1:0]   o_rx_data_rdy    // rx taken
);
  logic [NCH-1:0] tx_owner_r;

  ////////////////////////////////////////////////////////////////////////////
  // tx data may only flow on the channel that last got its tx control word
  always_ff @(posedge i_clk) begin
    if (i_rst) tx_owner_r <= '0;
    else if (|o_tx_ctrl_vld) tx_owner_r <= o_tx_ctrl_vld;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_MEM_HOLD: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
    && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request changed before ack");
  AST_MEM_GAP: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("no idle cycle after access");
  AST_ONE_GRANT: assert property ($onehot0({o_tx_ctrl_vld, o_rx_ctrl_vld}))
    else $error("several control pulses at once");
  AST_RX_UNUSED: assert property (o_rx_ctrl_vld[3:2] == 2'h0 && o_rx_data_rdy[3:2] == 2'h0)
    else $error("unused rx channel served");
  AST_ACTIVE_ONLY: assert property (((o_tx_ctrl_vld & ~i_tx_act) | (o_rx_ctrl_vld & ~i_rx_act)) == '0)
    else $error("inactive channel served");
  AST_CTRL_FIRST: assert property (o_tx_data_vld != '0 |-> o_tx_data_vld == tx_owner_r)
    else $error("tx data before control word");
  AST_TX_PACE: assert property ((o_tx_data_vld & ~i_tx_data_rdy) != '0 |=>
    o_tx_data_vld == $past(o_tx_data_vld) && $stable(o_tx_data)) else $error("tx offer dropped");
  AST_TX_BYTES: assert property (o_tx_data_vld != '0 |-> o_tx_data_bytes inside {[3'h1:3'h4]})
    else $error("bad tx byte count");
  AST_EOP_PULSE: assert property (o_tx_eop != '0 |=> o_tx_eop == '0)
    else $error("eop longer than one cycle");
  AST_RX_ONEHOT: assert property ($onehot0(o_rx_data_rdy))
    else $error("rx ready on several channels");
endmodule : pdma_top_asserts

bind pdma_top pdma_top_asserts #(.NCH(NCH), .CW(CW)) u_chk (.i_clk, .i_rst, .i_tx_act, .i_rx_act,
  .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .o_tx_ctrl_vld, .o_rx_ctrl_vld,
  .o_tx_data_vld, .i_tx_data_rdy, .o_tx_data, .o_tx_data_bytes, .o_tx_eop, .o_rx_data_rdy);

// [verif/pdma_mem_model.sv]
/*
  System memory model on the DMA master port: 256 words, latency alternating.
  Assumes one request held until its one-cycle acknowledge.
*/
`timescale 1ns/1ps

module pdma_mem_model (
  input  wire logic        i_clk,   // clock
  input  wire logic        i_rst,   // sync reset
  input  wire logic        i_req,   // access request
  input  wire logic        i_we,    // write
  input  wire logic [31:0] i_addr,  // byte address
  input  wire logic [31:0] i_wdata, // write data
  input  wire logic [3:0]  i_be,    // byte enables
  output logic             o_ack,   // one-cycle done
  output logic [31:0]      o_rdata  // read data
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_r;
  logic        slow_r;

  // prompt and slow answers alternate; idle data toggles so nothing stale passes
  // plain always: the bench preloads mem directly
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      wait_r  <= 2'h0;
      slow_r  <= 1'b0;
    end else if (!o_ack && i_req && wait_r == {slow_r, 1'b0}) begin
      o_ack   <= 1'b1;
      wait_r  <= 2'h0;
      slow_r  <= !slow_r;
      o_rdata <= mem[i_addr[9:2]];
      if (i_we) for (int b = 0; b < 4; b++) if (i_be[b]) mem[i_addr[9:2]][8*b +: 8] <= i_wdata[8*b +: 8];
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) wait_r <= wait_r + 2'h1;
    end
  end
endmodule : pdma_mem_model

// [verif/packet_descriptor_dma_bench.sv]
/*
  Testbench of the packet DMA: tx packet with wrap, refetch of the unready
  first descriptor, rx packet with status write-back.
  Assumes pdma_mem_model as system memory; the bench plays the MAC cores.
*/
`timescale 1ns/1ps
`include "pdma_cfg.svh"

module packet_descriptor_dma_bench;
  logic i_clk = 0, i_rst = 1, ack, last = 0;
  logic [3:0] tx_req = 0, rx_req = 0, tx_sreq = 0, rx_sreq = 0, tx_rdy = 0, rx_vld = 0, be;
  logic [3:0] tx_c, rx_c, tx_dv, rx_dr, eop, tx_eob, rx_eob, tx_un, tx_err, tx_h;
  logic [9:0] cw, rx_sts = 0;
  logic [31:0] addr, wd, rd, tx_d, rx_d = 0;
  logic req, we;
  logic [2:0] tx_b;
  int n_fail = 0, checks = 0, cycles = 0;

  pdma_top dut (.i_clk, .i_rst, .i_tx_act(4'hA), .i_rx_act(4'hF), .i_tx_tbl({64'h0, 32'h100, 32'h0}),
    .i_rx_tbl({96'h0, 32'h300}), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wd),
    .o_mem_be(be), .i_mem_ack(ack), .i_mem_rdata(rd), .i_tx_req(tx_req), .i_rx_req(rx_req),
    .o_tx_ctrl_vld(tx_c), .o_rx_ctrl_vld(rx_c), .o_ctrl_word(cw), .i_tx_sts_req(tx_sreq),
    .i_rx_sts_req(rx_sreq), .i_tx_sts(10'h2A5), .i_rx_sts(rx_sts), .o_tx_data_vld(tx_dv),
    .i_tx_data_rdy(tx_rdy), .o_tx_data(tx_d), .o_tx_data_bytes(tx_b), .o_tx_eop(eop),
    .i_rx_data_vld(rx_vld), .o_rx_data_rdy(rx_dr), .i_rx_data(rx_d), .i_rx_last(last),
    .i_rx_last_bytes(3'h2), .o_tx_unavail(tx_un), .o_rx_unavail(), .o_tx_desc_err(tx_err), .o_rx_desc_err(),
    .o_tx_eob(tx_eob), .o_rx_eob(rx_eob), .o_tx_halted(tx_h), .o_rx_halted());
  pdma_mem_model u_mem (.i_clk, .i_rst, .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .i_be(be), .o_ack(ack), .o_rdata(rd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // descriptor written back once its ready bit drops
  task automatic await_wb(input int w);
    for (int c = 0; c < 60 && u_mem.mem[w][31] !== 1'b0; c++) @(posedge i_clk);
  endtask : await_wb

  // core paces the words by taking every other cycle
  task automatic sc_tx;
    int got = 0, done = 0, ended = 0, ctl = 0;
    u_mem.mem[8'h40] = 32'hCD5A_0006;
    u_mem.mem[8'h41] = 32'h0000_0200;
    u_mem.mem[8'h80] = 32'h1122_3344;
    u_mem.mem[8'h81] = 32'h5566_7788;
    tx_req = 4'hB;
    for (int c = 0; c < 400 && !done; c++) begin
      @(posedge i_clk) #1;
      tx_rdy = {2'h0, c[0], 1'b0};
      if (ended) begin
        tx_sreq = 4'h2;
        tx_req  = 4'h0;
      end
      @(negedge i_clk);
      if (tx_c != 4'h0) begin
        check(tx_c, 4'h2);
        check(cw, 10'h15A);
        ctl = 1;
      end
      if ((tx_dv & tx_rdy) != 4'h0) begin
        check(ctl, 1);
        check(tx_b, got ? 3'h2 : 3'h4);
        check(got ? tx_d[31:16] : tx_d, got ? 32'h5566 : 32'h1122_3344);
        got++;
      end
      if (eop[1]) ended = 1;
      if (tx_eob[1]) done = 1;
    end
    check(got, 2);
    check(done, 1);
    await_wb(8'h40);
    check(u_mem.mem[8'h40], 32'h4EA5_0006);
  endtask : sc_tx

  // after the wrap the next fetch is at table start, now not ready
  task automatic sc_wrap;
    logic [31:0] first = 32'hFFFF_FFFF;
    int un = 0;
    @(posedge i_clk) #1;
    tx_req = 4'h2;
    tx_sreq = 4'h0;
    for (int c = 0; c < 200 && !un; c++) begin
      @(negedge i_clk);
      if (req && first === 32'hFFFF_FFFF) first = addr;
      if (tx_un[1]) un = 1;
      check(tx_c, 4'h0);
      check({tx_err, tx_h}, 8'h0);
    end
    check(first, 32'h100);
    check(un, 1);
    @(posedge i_clk) #1;
    tx_req = 4'h0;
  endtask : sc_wrap

  task automatic sc_rx;
    int k = 0, take = 0, done = 0;
    u_mem.mem[8'hC0] = 32'h8400_0008;
    u_mem.mem[8'hC1] = 32'h0000_0380;
    rx_req = 4'h5;
    for (int c = 0; c < 400 && !done; c++) begin
      @(posedge i_clk) #1;
      k = k + take;
      rx_vld = {3'h0, k < 2};
      last = (k == 1);
      rx_d = (k == 0) ? 32'hA1B2_C3D4 : (k == 1) ? 32'hE5F6_9999 : ~rx_d;
      if (k == 2) begin
        rx_req = 4'h0;
        rx_sreq = 4'h1;
        rx_sts = 10'h0C3;
      end
      @(negedge i_clk);
      take = rx_vld[0] & rx_dr[0];
      if (rx_c != 4'h0) check(rx_c, 4'h1);
      if (rx_eob[0]) done = 1;
    end
    check(done, 1);
    await_wb(8'hC0);
    check(u_mem.mem[8'hC0], 32'h0CC3_0006);
    check(u_mem.mem[8'hE0], 32'hA1B2_C3D4);
    check(u_mem.mem[8'hE1][31:16], 32'hE5F6);
    rx_sreq = 4'h0;
  endtask : sc_rx

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_rst = 0;
    sc_tx();
    sc_wrap();
    sc_rx();
    wrap_up();
  end
endmodule : packet_descriptor_dma_bench
